// File: include/dsp_map.svh
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// ==========================================================================
// Register addresses on the special-function port.
`define DSP_ADDR_POWER 8'h87
`define DSP_ADDR_P0_CTRL 8'h98
`define DSP_ADDR_P1_DATA 8'h9a
`define DSP_ADDR_P1_EXT 8'hc4
`define DSP_ADDR_P1_CTRL 8'hf8

// ==========================================================================
// Field positions, shared by the control registers of both ports.
`define DSP_BIT_MODE_HI 7
`define DSP_BIT_MODE_LO 6
`define DSP_BIT_FILTER 5
`define DSP_BIT_RX_EN 4
`define DSP_BIT_TX9 3
`define DSP_BIT_RX9 2
`define DSP_BIT_TX_DONE 1
`define DSP_BIT_RX_DONE 0
`define DSP_BIT_DOUBLER 7
`define DSP_BIT_VIEW 6

// ==========================================================================
// Reset values, baud divisors and receive buffer size.
`define DSP_RST_BYTE 8'h00
`define DSP_DIV_M0_SLOW 7'h0c
`define DSP_DIV_M0_FAST 7'h02
`define DSP_DIV_M2_SLOW 7'h40
`define DSP_DIV_M2_FAST 7'h20
`define DSP_DIV_TIMER 7'h10
`define DSP_FIFO_DEPTH 16
`define DSP_FIFO_WIDTH 8

`endif

// File: include/dsp_pkg.sv
package dsp_pkg;

    // Port operating modes, encoded as the two mode-select bits.
    typedef enum logic [1:0] {
        DSP_MODE_SYNC8 = 2'b00,
        DSP_MODE_ASYNC10 = 2'b01,
        DSP_MODE_ASYNC11 = 2'b10,
        DSP_MODE_ASYNC11T = 2'b11
    } dsp_mode_t;

    // Receive sequencer, Gray coded along idle, sync receive, async listen.
    typedef enum logic [1:0] {
        DSP_ST_IDLE = 2'b00,
        DSP_ST_SYNC_RX = 2'b01,
        DSP_ST_ASYNC_RX = 2'b11
    } dsp_state_t;

endpackage

// File: design/dsp_ctrl.sv
// Operation
// - Filter enable meaning depends on mode; mode 0 uses it to pick the fast or slow divisor.
// - Mode 1 with filter: accept only stop bit 1 and address match.
// - Modes 2,3 with filter: accept only ninth bit 1 and address match.
// - Receive enable 0 disables reception; 1 enables in modes 1 to 3.
// - Mode 0 reception starts only with receive enable 1 and done 0.
// - Ninth transmit bit sent in modes 2,3; ignored in modes 0,1.
// - Ninth received bit captures ninth bit or stop bit; unused mode 0.
// - Transmit-done flag set by hardware when a frame is sent.
// - Set transmit-done requests interrupt when enabled; software clears.
// - Receive-done flag set after eighth bit or at stop bit.
// - With filter on, done flag and ninth bit update only if accepted.
// - Set receive-done requests interrupt when enabled; software clears.
// - Port 0 doubler doubles mode 2, or modes 1,3 on timer 1.
// - Port 0 view select routes control bit 7 to mode or error.
// - Power register: doubler bit 7, view bit 6, bit 5 unimplemented.
// - Mode bits encode frames; port 1 modes 1,3 divide timer by 16.
// - Port 1 view select routes control bit 7 to mode or error.
// - Mode 0 is half duplex with device-driven shift clock.

`include "dsp_map.svh"

// ==========================================================================
// Receive data buffer.
module dsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_C = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
        logic room;
        logic nonempty;
    } dsp_fifo_state_t;

    dsp_fifo_state_t s_q;
    dsp_fifo_state_t s_d;
    logic push;
    logic pop;

    assign push = in_valid && s_q.room;
    assign pop = out_ready && s_q.nonempty;
    assign in_ready = s_q.room;
    assign out_valid = s_q.nonempty;
    assign out_data = s_q.mem[s_q.rd];

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = AW'(s_q.wr + 1'b1);
        end
        if (pop) begin
            s_d.rd = AW'(s_q.rd + 1'b1);
        end
        if (push && !pop) begin
            s_d.cnt = CW'(s_q.cnt + 1'b1);
        end else if (pop && !push) begin
            s_d.cnt = CW'(s_q.cnt - 1'b1);
        end
        // Flags are registered so the ready seen by the source is a flop.
        s_d.room = (s_d.cnt != FULL_C);
        s_d.nonempty = (s_d.cnt != '0);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ==========================================================================
// Serial port control and status.
module dsp_ctrl
    import dsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic p1_int_en,
    input wire logic p1_rx_frame_done,
    input wire logic [7:0] p1_rx_byte,
    input wire logic p1_rx_ninth,
    input wire logic p1_rx_addr_match,
    input wire logic p1_rx_frame_error,
    input wire logic p1_tx_frame_done,
    input wire logic p0_frame_error,
    input wire logic p0_timer1_source,
    output logic p1_irq,
    output logic p1_rx_enable,
    output logic p1_sync_rx_start,
    output logic p1_ninth_tx_bit,
    output logic p1_tx_pin_is_clock,
    output logic [1:0] p1_mode,
    output logic [6:0] p1_baud_divisor,
    output logic p1_rx_ready,
    output logic p0_rate_double
);
    // ======================================================================
    // State.
    typedef struct packed {
        logic p1_mode_hi;
        logic p1_mode_lo;
        logic p1_multiproc_filter_en;
        logic p1_rx_en;
        logic p1_ninth_tx_bit;
        logic p1_ninth_rx_bit;
        logic p1_tx_done_flag;
        logic p1_rx_done_flag;
        logic p1_framing_error;
        logic p1_baud_doubler;
        logic p1_error_view_select;
        logic p0_baud_doubler;
        logic p0_error_view_select;
        logic p0_mode_hi;
        logic p0_framing_error;
        logic [6:0] p0_low_bits;
        logic [7:0] rdata;
        logic irq;
        logic rx_enable;
        logic sync_start;
        logic tx_ninth;
        logic tx_clk_pin;
        logic [6:0] divisor;
        logic rate_double;
        dsp_state_t state;
    } dsp_ctrl_state_t;

    dsp_ctrl_state_t s_q;
    dsp_ctrl_state_t s_d;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic frame_accepted;
    dsp_mode_t mode;

    // ======================================================================
    // Helpers.
    function automatic dsp_mode_t mode_of(input logic hi, input logic lo);
        return dsp_mode_t'({hi, lo});
    endfunction

    // A frame counts only if the filter is off or it carries the marker
    // bit and an address match; mode 0 never filters.
    function automatic logic accept(input dsp_mode_t m, input logic filt,
                                    input logic ninth, input logic hit);
        if (m == DSP_MODE_SYNC8) begin
            return 1'b1;
        end
        return !filt || (ninth && hit);
    endfunction

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] addr,
                                    input logic we);
        return we && (a == addr);
    endfunction

    assign mode = mode_of(s_q.p1_mode_hi, s_q.p1_mode_lo);
    assign frame_accepted = p1_rx_frame_done && (s_q.state != DSP_ST_IDLE) &&
        accept(mode, s_q.p1_multiproc_filter_en, p1_rx_ninth, p1_rx_addr_match);
    assign fifo_pop = reg_read && (reg_addr == `DSP_ADDR_P1_DATA) && fifo_out_valid;

    // ======================================================================
    // Received bytes wait here; a full buffer holds off the receiver.
    dsp_fifo #(
        .WIDTH(`DSP_FIFO_WIDTH),
        .DEPTH(`DSP_FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(frame_accepted),
        .in_ready(fifo_in_ready),
        .in_data(p1_rx_byte),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ======================================================================
    // Next state.
    always_comb begin
        dsp_mode_t nm;
        nm = DSP_MODE_SYNC8;
        s_d = s_q;

        // Register writes.
        if (wr_hit(reg_addr, `DSP_ADDR_P1_CTRL, reg_write)) begin
            if (s_q.p1_error_view_select) begin
                s_d.p1_framing_error = reg_wdata[`DSP_BIT_MODE_HI];
            end else begin
                s_d.p1_mode_hi = reg_wdata[`DSP_BIT_MODE_HI];
            end
            s_d.p1_mode_lo = reg_wdata[`DSP_BIT_MODE_LO];
            s_d.p1_multiproc_filter_en = reg_wdata[`DSP_BIT_FILTER];
            s_d.p1_rx_en = reg_wdata[`DSP_BIT_RX_EN];
            s_d.p1_ninth_tx_bit = reg_wdata[`DSP_BIT_TX9];
            s_d.p1_ninth_rx_bit = reg_wdata[`DSP_BIT_RX9];
            s_d.p1_tx_done_flag = reg_wdata[`DSP_BIT_TX_DONE];
            s_d.p1_rx_done_flag = reg_wdata[`DSP_BIT_RX_DONE];
        end
        if (wr_hit(reg_addr, `DSP_ADDR_P1_EXT, reg_write)) begin
            s_d.p1_baud_doubler = reg_wdata[`DSP_BIT_DOUBLER];
            s_d.p1_error_view_select = reg_wdata[`DSP_BIT_VIEW];
        end
        if (wr_hit(reg_addr, `DSP_ADDR_POWER, reg_write)) begin
            s_d.p0_baud_doubler = reg_wdata[`DSP_BIT_DOUBLER];
            s_d.p0_error_view_select = reg_wdata[`DSP_BIT_VIEW];
        end
        if (wr_hit(reg_addr, `DSP_ADDR_P0_CTRL, reg_write)) begin
            if (s_q.p0_error_view_select) begin
                s_d.p0_framing_error = reg_wdata[`DSP_BIT_MODE_HI];
            end else begin
                s_d.p0_mode_hi = reg_wdata[`DSP_BIT_MODE_HI];
            end
            s_d.p0_low_bits = reg_wdata[6:0];
        end

        // Hardware events come last so a set beats a same-cycle clear.
        if (p1_tx_frame_done) begin
            s_d.p1_tx_done_flag = 1'b1;
        end
        if (frame_accepted) begin
            s_d.p1_rx_done_flag = 1'b1;
            if (mode != DSP_MODE_SYNC8) begin
                s_d.p1_ninth_rx_bit = p1_rx_ninth;
            end
        end
        if (p1_rx_frame_done && p1_rx_frame_error && mode != DSP_MODE_SYNC8) begin
            s_d.p1_framing_error = 1'b1;
        end
        if (p0_frame_error) begin
            s_d.p0_framing_error = 1'b1;
        end

        // Receive sequencer.
        s_d.sync_start = 1'b0;
        case (s_q.state)
            DSP_ST_IDLE: begin
                if (s_q.p1_rx_en && mode == DSP_MODE_SYNC8 && !s_q.p1_rx_done_flag) begin
                    s_d.state = DSP_ST_SYNC_RX;
                    s_d.sync_start = 1'b1;
                end else if (s_q.p1_rx_en && mode != DSP_MODE_SYNC8) begin
                    s_d.state = DSP_ST_ASYNC_RX;
                end
            end
            DSP_ST_SYNC_RX: begin
                if (p1_rx_frame_done || !s_q.p1_rx_en) begin
                    s_d.state = DSP_ST_IDLE;
                end
            end
            DSP_ST_ASYNC_RX: begin
                if (!s_q.p1_rx_en || mode == DSP_MODE_SYNC8) begin
                    s_d.state = DSP_ST_IDLE;
                end
            end
            default: begin
                s_d.state = DSP_ST_IDLE;
            end
        endcase

        // Registered outputs, computed from the settled next state.
        nm = mode_of(s_d.p1_mode_hi, s_d.p1_mode_lo);
        s_d.rx_enable = s_d.p1_rx_en && (nm != DSP_MODE_SYNC8);
        s_d.tx_ninth = nm[1] && s_d.p1_ninth_tx_bit;
        s_d.tx_clk_pin = (nm == DSP_MODE_SYNC8);
        s_d.irq = p1_int_en && (s_d.p1_tx_done_flag || s_d.p1_rx_done_flag);
        case (nm)
            DSP_MODE_SYNC8: begin
                s_d.divisor = s_d.p1_multiproc_filter_en ? `DSP_DIV_M0_FAST
                                                         : `DSP_DIV_M0_SLOW;
            end
            DSP_MODE_ASYNC11: begin
                s_d.divisor = s_d.p1_baud_doubler ? `DSP_DIV_M2_FAST
                                                  : `DSP_DIV_M2_SLOW;
            end
            default: begin
                s_d.divisor = `DSP_DIV_TIMER;
            end
        endcase
        // Port 0 only doubles on the timer 1 source in the timer modes.
        s_d.rate_double = s_d.p0_baud_doubler &&
            ((s_d.p0_mode_hi && !s_d.p0_low_bits[`DSP_BIT_MODE_LO]) ||
             (s_d.p0_low_bits[`DSP_BIT_MODE_LO] && p0_timer1_source));

        // Read data appear in the cycle after the strobe only.
        s_d.rdata = `DSP_RST_BYTE;
        if (reg_read) begin
            case (reg_addr)
                `DSP_ADDR_P1_CTRL: begin
                    s_d.rdata = {s_q.p1_error_view_select ? s_q.p1_framing_error
                                                          : s_q.p1_mode_hi,
                                 s_q.p1_mode_lo, s_q.p1_multiproc_filter_en,
                                 s_q.p1_rx_en, s_q.p1_ninth_tx_bit, s_q.p1_ninth_rx_bit,
                                 s_q.p1_tx_done_flag, s_q.p1_rx_done_flag};
                end
                `DSP_ADDR_P1_EXT: begin
                    s_d.rdata = {s_q.p1_baud_doubler, s_q.p1_error_view_select, 6'h00};
                end
                `DSP_ADDR_POWER: begin
                    s_d.rdata = {s_q.p0_baud_doubler, s_q.p0_error_view_select,
                                 6'h00};
                end
                `DSP_ADDR_P0_CTRL: begin
                    s_d.rdata = {s_q.p0_error_view_select ? s_q.p0_framing_error
                                                          : s_q.p0_mode_hi,
                                 s_q.p0_low_bits};
                end
                `DSP_ADDR_P1_DATA: begin
                    s_d.rdata = fifo_out_valid ? fifo_out_data : `DSP_RST_BYTE;
                end
                default: begin
                    s_d.rdata = `DSP_RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs.
    assign reg_rdata = s_q.rdata;
    assign p1_irq = s_q.irq;
    assign p1_rx_enable = s_q.rx_enable;
    assign p1_sync_rx_start = s_q.sync_start;
    assign p1_ninth_tx_bit = s_q.tx_ninth;
    assign p1_tx_pin_is_clock = s_q.tx_clk_pin;
    assign p1_mode = {s_q.p1_mode_hi, s_q.p1_mode_lo};
    assign p1_baud_divisor = s_q.divisor;
    assign p1_rx_ready = fifo_in_ready;
    assign p0_rate_double = s_q.rate_double;
endmodule

// File: verif/dsp_ctrl_checker.sv
`include "dsp_map.svh"

// ==========================================================================
// Port-level checks of the serial port control block.
module dsp_ctrl_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic p1_int_en,
    input wire logic p1_rx_frame_done,
    input wire logic [7:0] p1_rx_byte,
    input wire logic p1_rx_ninth,
    input wire logic p1_rx_addr_match,
    input wire logic p1_rx_frame_error,
    input wire logic p1_tx_frame_done,
    input wire logic p0_frame_error,
    input wire logic p0_timer1_source,
    input wire logic p1_irq,
    input wire logic p1_rx_enable,
    input wire logic p1_sync_rx_start,
    input wire logic p1_ninth_tx_bit,
    input wire logic p1_tx_pin_is_clock,
    input wire logic [1:0] p1_mode,
    input wire logic [6:0] p1_baud_divisor,
    input wire logic p1_rx_ready,
    input wire logic p0_rate_double
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_TX_IRQ: assert property (
        p1_tx_frame_done ##1 (p1_int_en && !(reg_write && reg_addr == `DSP_ADDR_P1_CTRL))
        |=> p1_irq) else $error("tx done gave no irq");
    AST_IRQ_MASKED: assert property (
        !$past(p1_int_en) |-> !p1_irq) else $error("irq while disabled");
    AST_RX_EN_M0: assert property (
        $past(p1_mode) == 2'b00 && p1_mode == 2'b00 |-> !p1_rx_enable)
        else $error("rx enable in mode 0");
    AST_TX_CLK: assert property (
        $past(rst_n) && $stable(p1_mode) |-> p1_tx_pin_is_clock == (p1_mode == 2'b00))
        else $error("tx pin clock role wrong");
    AST_NINTH_TX: assert property (
        $stable(p1_mode) && !p1_mode[1] |-> !p1_ninth_tx_bit) else $error("ninth bit sent");
    AST_DIV_TIMER: assert property (
        $past(rst_n) && $stable(p1_mode) && p1_mode[0] |-> p1_baud_divisor == `DSP_DIV_TIMER)
        else $error("timer divisor wrong");
    AST_DIV_M0: assert property (
        $past(rst_n) && $stable(p1_mode) && p1_mode == 2'b00
        |-> p1_baud_divisor inside {`DSP_DIV_M0_SLOW, `DSP_DIV_M0_FAST})
        else $error("mode 0 divisor wrong");
    AST_DIV_M2: assert property (
        $past(rst_n) && $stable(p1_mode) && p1_mode == 2'b10
        |-> p1_baud_divisor inside {`DSP_DIV_M2_SLOW, `DSP_DIV_M2_FAST})
        else $error("mode 2 divisor wrong");
    AST_START_PULSE: assert property (
        p1_sync_rx_start |=> !p1_sync_rx_start) else $error("start pulse too long");
    AST_START_M0: assert property (
        p1_sync_rx_start |-> p1_mode == 2'b00 && !p1_rx_enable)
        else $error("start outside mode 0");
    AST_PWR_RD: assert property (
        $past(reg_read) && $past(reg_addr) == `DSP_ADDR_POWER |-> reg_rdata[5:0] == 6'h00)
        else $error("power low bits not zero");

    cover property (p1_sync_rx_start);
    cover property (p1_irq);
    cover property (!p1_rx_ready);
    cover property (p0_rate_double);
endmodule

bind dsp_ctrl dsp_ctrl_checker u_chk (.*);

// File: verif/dsp_rx_engine.sv
// ==========================================================================
// Receive shifter stand-in: delivers whole frames to the control block.
module dsp_rx_engine (
    input wire logic ref_clk,
    input wire logic [1:0] p1_mode,
    input wire logic p1_rx_enable,
    input wire logic p1_sync_rx_start,
    input wire logic p1_rx_ready,
    output logic p1_rx_frame_done,
    output logic [7:0] p1_rx_byte,
    output logic p1_rx_ninth,
    output logic p1_rx_addr_match,
    output logic p1_rx_frame_error
);
    timeunit 1ns;
    timeprecision 1ns;
    int n_start = 0;
    int n_used = 0;

    initial begin
        p1_rx_frame_done = 1'b0;
        p1_rx_byte = 8'h00;
        {p1_rx_ninth, p1_rx_addr_match, p1_rx_frame_error} = 3'h0;
    end

    // In mode 0 this side is a slave and may shift only after the start pulse.
    always @(posedge ref_clk) begin
        if (p1_sync_rx_start === 1'b1) n_start <= n_start + 1;
    end

    // A frame that never gets permission is still delivered, to prove it is ignored.
    task automatic send(input logic [7:0] b, input logic [2:0] f);
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge ref_clk);
            if (p1_rx_ready && (p1_mode == 2'b00 ? n_start > n_used : p1_rx_enable)) break;
        end
        if (p1_mode == 2'b00) n_used++;
        @(posedge ref_clk);
        p1_rx_frame_done <= 1'b1;
        p1_rx_byte <= b;
        {p1_rx_ninth, p1_rx_addr_match, p1_rx_frame_error} <= f;
        @(posedge ref_clk);
        p1_rx_frame_done <= 1'b0;
        p1_rx_byte <= ~b;
        {p1_rx_ninth, p1_rx_addr_match, p1_rx_frame_error} <= ~f;
    endtask
endmodule

// File: verif/dsp_ctrl_tb.sv
`include "dsp_map.svh"

module dsp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CT = `DSP_ADDR_P1_CTRL;
    localparam logic [7:0] PW = `DSP_ADDR_POWER;
    localparam logic [7:0] P0 = `DSP_ADDR_P0_CTRL;
    localparam logic [7:0] DT = `DSP_ADDR_P1_DATA;
    localparam logic [7:0] EX = `DSP_ADDR_P1_EXT;
    logic ref_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, p1_int_en = 0;
    logic p1_tx_frame_done = 0, p0_frame_error = 0, p0_timer1_source = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, p1_rx_byte;
    logic p1_rx_frame_done, p1_rx_ninth, p1_rx_addr_match, p1_rx_frame_error;
    logic p1_irq, p1_rx_enable, p1_sync_rx_start, p1_ninth_tx_bit, p1_tx_pin_is_clock;
    logic p1_rx_ready, p0_rate_double;
    logic [1:0] p1_mode;
    logic [6:0] p1_baud_divisor;
    int n_fail = 0, checked = 0;

    dsp_ctrl dut (.*);
    dsp_rx_engine eng (.*);
    always #25 ref_clk = ~ref_clk;

    // ======================================================================
    // Shared bus and comparison tasks.
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic frame(input logic [7:0] c, input logic [2:0] f, input logic [7:0] e, d);
        wr(CT, c);
        eng.send(8'h3c, f);
        cyc(2);
        rd(CT, e);
        chk(8'(p1_irq), 8'(e[0]));
        rd(DT, d);
    endtask

    // ======================================================================
    // Scenarios.
    task automatic t_reset();
        cyc(2);
        chk(8'(p1_tx_pin_is_clock), 8'h01);
        chk(8'(p1_baud_divisor), 8'(`DSP_DIV_M0_SLOW));
        rd(PW, 8'h00);
        rd(CT, 8'h00);
        rd(EX, 8'h00);
        rd(8'h55, 8'h00);
        rd(DT, 8'h00);
    endtask
    task automatic t_port0();
        wr(PW, 8'hff);
        rd(PW, 8'hc0);
        wr(PW, 8'h80);
        wr(P0, 8'h80);
        cyc(2);
        chk(8'(p0_rate_double), 8'h01);
        wr(P0, 8'h40);
        cyc(2);
        chk(8'(p0_rate_double), 8'h00);
        @(posedge ref_clk) p0_timer1_source <= 1'b1;
        cyc(2);
        chk(8'(p0_rate_double), 8'h01);
        wr(PW, 8'h40);
        cyc(2);
        chk(8'(p0_rate_double), 8'h00);
        wr(P0, 8'h7f);
        rd(P0, 8'h7f);
        @(posedge ref_clk) p0_frame_error <= 1'b1;
        @(posedge ref_clk) p0_frame_error <= 1'b0;
        rd(P0, 8'hff);
        wr(PW, 8'h00);
        rd(P0, 8'h7f);
    endtask
    task automatic t_tx();
        wr(CT, 8'h88);
        wr(EX, 8'h80);
        cyc(2);
        chk(8'(p1_ninth_tx_bit), 8'h01);
        chk(8'(p1_mode), 8'h02);
        chk(8'(p1_tx_pin_is_clock), 8'h00);
        chk(8'(p1_baud_divisor), 8'(`DSP_DIV_M2_FAST));
        wr(EX, 8'h00);
        wr(CT, 8'h48);
        cyc(2);
        chk(8'(p1_ninth_tx_bit), 8'h00);
        chk(8'(p1_rx_enable), 8'h00);
        chk(8'(p1_baud_divisor), 8'(`DSP_DIV_TIMER));
        @(posedge ref_clk) p1_int_en <= 1'b1;
        @(posedge ref_clk) p1_tx_frame_done <= 1'b1;
        @(posedge ref_clk) p1_tx_frame_done <= 1'b0;
        cyc(8);
        chk(8'(p1_irq), 8'h01);
        rd(CT, 8'h4a);
        wr(CT, 8'h48);
        cyc(2);
        chk(8'(p1_irq), 8'h00);
        @(posedge ref_clk) p1_int_en <= 1'b0;
        wr(CT, 8'h4a);
        rd(CT, 8'h4a);
        chk(8'(p1_irq), 8'h00);
        @(posedge ref_clk) p1_int_en <= 1'b1;
        cyc(2);
        chk(8'(p1_irq), 8'h01);
    endtask
    task automatic t_filter();
        frame(8'hb0, 3'b010, 8'hb0, 8'h00);
        frame(8'hb0, 3'b100, 8'hb0, 8'h00);
        frame(8'hb0, 3'b110, 8'hb5, 8'h3c);
        frame(8'hd0, 3'b000, 8'hd1, 8'h3c);
        frame(8'h70, 3'b010, 8'h70, 8'h00);
        frame(8'h70, 3'b110, 8'h75, 8'h3c);
        frame(8'h54, 3'b000, 8'h51, 8'h3c);
        frame(8'h40, 3'b110, 8'h40, 8'h00);
        frame(8'h50, 3'b101, 8'h55, 8'h3c);
        wr(EX, 8'h40);
        rd(CT, 8'hd5);
        wr(EX, 8'h00);
    endtask
    task automatic t_fifo();
        wr(CT, 8'h50);
        for (int i = 0; i < `DSP_FIFO_DEPTH; i++) eng.send(8'h30 + 8'(i), 3'b000);
        cyc(2);
        chk(8'(p1_rx_ready), 8'h00);
        fork
            eng.send(8'h99, 3'b000);
            for (int i = 0; i < `DSP_FIFO_DEPTH; i++) rd(DT, 8'h30 + 8'(i));
        join
        rd(DT, 8'h99);
        rd(DT, 8'h00);
    endtask
    task automatic t_mode0();
        wr(CT, 8'h00);
        cyc(3);
        wr(CT, 8'h30);
        cyc(4);
        chk(8'(eng.n_start), 8'h01);
        chk(8'(p1_rx_enable), 8'h00);
        chk(8'(p1_baud_divisor), 8'(`DSP_DIV_M0_FAST));
        eng.send(8'h5a, 3'b100);
        cyc(6);
        rd(CT, 8'h31);
        rd(DT, 8'h5a);
        chk(8'(eng.n_start), 8'h01);
        wr(CT, 8'h30);
        cyc(4);
        chk(8'(eng.n_start), 8'h02);
    endtask

    // ======================================================================
    // Run control.
    task automatic tally_and_finish();
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_port0();
        t_tx();
        t_filter();
        t_fifo();
        t_mode0();
        tally_and_finish();
    end
endmodule
